// ---- design/thd_defines.svh ----
// register map, field positions, reset values and timing constants of the shutdown timer
`ifndef THD_DEFINES_SVH
`define THD_DEFINES_SVH

`define THD_OFF_COUNT 8'h00
`define THD_OFF_PERIOD 8'h04
`define THD_OFF_CMP_SHD 8'h08
`define THD_OFF_CMP_ACT 8'h0c
`define THD_OFF_CTRL 8'h10
`define THD_OFF_CMD 8'h14
`define THD_OFF_STATUS 8'h18

`define THD_CMD_RUN_SET 0
`define THD_CMD_RUN_CLR 1
`define THD_CMD_CNT_CLR 2
`define THD_CMD_SREQ_SET 3
`define THD_CMD_SREQ_CLR 4
`define THD_CMD_ST_CLR 5

`define THD_RST_CTRL 32'h0000_0000
`define THD_RST_WORD 16'h0000
`define THD_MODE_HYST 4'h9
`define THD_PRE_EXTRA 4'h8
`define THD_PSC_W 15
`define THD_RESP_OK 2'b00
`define THD_RESP_ERR 2'b10
`define THD_NCH 3

`endif

// ---- design/thd_pkg.sv ----
// types shared by the shutdown timer block
package thd_pkg;
    // software control word, high bits first, exactly one bus word wide
    typedef struct packed {
        logic [3:0] unused;
        logic [3:0] mode2;
        logic [3:0] mode1;
        logic [3:0] mode0;
        logic [5:0] spare;
        logic [1:0] trig_dir;
        logic [2:0] trig_evt;
        logic single_shot;
        logic extra_pre;
        logic [2:0] clk_div;
    } thd_ctrl_t;

    // companion timer events, one-cycle pulses plus its direction level
    typedef struct packed {
        logic [2:0] cmp_match;
        logic period_match;
        logic zero_match;
        logic count_down;
        logic hall_change;
    } thd_t12_ev_t;
endpackage

// ---- design/thd_timer.sv ----
// up-counting period timer with shadow reload, companion trigger and comparator shutdown
//
// Notes on behaviour
// - hysteresis mode code 1001 clears state bit on comparator input falling edge
// - the clear is triggered by a negative transition on the comparator pin
// - comparator low forces passive output; high lets state bit drive output
// - state bit sets only while comparator input is high
// - timer is a 16-bit up-only counter
// - count rate is clock over 2^select, times 256 more with extra prescale
// - prescaler held in reset while timer stopped
// - count equal to period flags match and wraps to zero next tick
// - period is period value plus one timer clocks
// - zero match is active whenever count is zero
// - count writes ignored while running, immediate when stopped; reads give count
// - period writes go to shadow, reads return the active period
// - shadow request set and cleared by write-one command bits
// - with request set, transfer pulses on period wrap or while stopped
// - transfer pulse copies shadow period and shadow compare to active
// - run set command starts timer, run clear command stops it
// - count clear command zeroes count and nothing else
// - single shot clears run flag as counter wraps after period
// - selected companion event sets run flag by hardware
// - event select and direction qualifier choose the trigger
// - event codes: none, compare 0/1/2, any compare, period, zero up, hall
// - direction codes: none, companion up, companion down, either
`timescale 1ns/1ps
`include "thd_defines.svh"

module thd_timer
    import thd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_s_awaddr,
    input wire logic i_s_awvalid,
    output logic o_s_awready,
    input wire logic [31:0] i_s_wdata,
    input wire logic [3:0] i_s_wstrb,
    input wire logic i_s_wvalid,
    output logic o_s_wready,
    output logic [1:0] o_s_bresp,
    output logic o_s_bvalid,
    input wire logic i_s_bready,
    input wire logic [7:0] i_s_araddr,
    input wire logic i_s_arvalid,
    output logic o_s_arready,
    output logic [31:0] o_s_rdata,
    output logic [1:0] o_s_rresp,
    output logic o_s_rvalid,
    input wire logic i_s_rready,
    input wire thd_t12_ev_t i_t12,
    input wire logic [2:0] i_chan_set,
    input wire logic [2:0] i_chan_cmp,
    output logic [2:0] o_chan_out,
    output logic o_period_match,
    output logic o_zero_match,
    output logic o_shadow_xfer
);
    // bus side state
    logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
    logic [7:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic do_wr;
    // timer state
    thd_ctrl_t ctrl_q;
    logic run_q, sreq_q;
    logic [15:0] cnt_q, per_q, per_shd_q, cmp_q, cmp_shd_q;
    logic [`THD_PSC_W-1:0] psc_q;
    logic [`THD_PSC_W-1:0] psc_mask;
    logic [3:0] psc_sh;
    logic tick, pm, wrap, xfer, trig, evt;
    logic [2:0] pos_m_q, pos_q, pos_d1_q, st_q, fall, hyst;
    logic cmd_wr, cnt_wr;
    logic [31:0] cmd;

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // address and data are taken in either order and held until both are here
    assign o_s_awready = !aw_hold_q && !bvalid_q;
    assign o_s_wready = !w_hold_q && !bvalid_q;
    assign do_wr = aw_hold_q && w_hold_q;
    assign o_s_bvalid = bvalid_q;
    assign o_s_bresp = bresp_q;
    assign o_s_arready = !rvalid_q;
    assign o_s_rvalid = rvalid_q;
    assign o_s_rdata = rdata_q;
    assign o_s_rresp = rresp_q;

    // write channel capture and response
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `THD_RESP_OK;
            waddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (i_s_awvalid && o_s_awready) begin
                aw_hold_q <= 1'b1;
                waddr_q <= i_s_awaddr;
            end
            if (i_s_wvalid && o_s_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= i_s_wdata;
                wstrb_q <= i_s_wstrb;
            end
            if (do_wr) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (waddr_q > `THD_OFF_STATUS || waddr_q[1:0] != 2'b00 ||
                            waddr_q == `THD_OFF_CMP_ACT || waddr_q == `THD_OFF_STATUS)
                           ? `THD_RESP_ERR : `THD_RESP_OK;
            end else if (bvalid_q && i_s_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // read mux, answered one cycle after the address is taken
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `THD_RESP_OK;
        end else if (i_s_arvalid && o_s_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= `THD_RESP_OK;
            case (i_s_araddr)
                `THD_OFF_COUNT: rdata_q <= {16'h0000, cnt_q};
                `THD_OFF_PERIOD: rdata_q <= {16'h0000, per_q};
                `THD_OFF_CMP_SHD: rdata_q <= {16'h0000, cmp_shd_q};
                `THD_OFF_CMP_ACT: rdata_q <= {16'h0000, cmp_q};
                `THD_OFF_CTRL: rdata_q <= ctrl_q;
                `THD_OFF_CMD: rdata_q <= 32'h0000_0000; // command bits read as zero
                `THD_OFF_STATUS: rdata_q <= {22'h0, pos_q, st_q, o_period_match,
                                             o_zero_match, sreq_q, run_q};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= `THD_RESP_ERR;
                end
            endcase
        end else if (rvalid_q && i_s_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // decoded write strobes; commands act on byte lane 0 only
    assign cmd_wr = do_wr && waddr_q == `THD_OFF_CMD && wstrb_q[0];
    assign cmd = cmd_wr ? wdata_q : 32'h0000_0000;
    assign cnt_wr = do_wr && waddr_q == `THD_OFF_COUNT;

    // configuration and shadow registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q <= `THD_RST_CTRL;
            per_shd_q <= `THD_RST_WORD;
            cmp_shd_q <= `THD_RST_WORD;
        end else if (do_wr) begin
            if (waddr_q == `THD_OFF_CTRL) begin
                ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
            end
            if (waddr_q == `THD_OFF_PERIOD) begin
                per_shd_q <= 16'(merge({16'h0000, per_shd_q}, wdata_q, wstrb_q));
            end
            if (waddr_q == `THD_OFF_CMP_SHD) begin
                cmp_shd_q <= 16'(merge({16'h0000, cmp_shd_q}, wdata_q, wstrb_q));
            end
        end
    end

    // prescaler: a free counter tested against a power-of-two mask, so every
    // divisor is an exact 2^n without a reload value
    assign psc_sh = ctrl_q.extra_pre ? ({1'b0, ctrl_q.clk_div} + `THD_PRE_EXTRA)
                                     : {1'b0, ctrl_q.clk_div};
    assign psc_mask = `THD_PSC_W'((16'h0001 << psc_sh) - 16'h0001);
    // at divisor one the mask is zero, so a tick comes in the very first running cycle
    assign tick = run_q && ((psc_q & psc_mask) == psc_mask);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            psc_q <= '0;
        end else if (!run_q) begin
            psc_q <= '0;
        end else begin
            psc_q <= psc_q + 1'b1;
        end
    end

    // period compare and wrap; the wrap tick is the end of a period
    assign pm = (cnt_q == per_q);
    assign wrap = tick && pm;

    // counter; clear command beats the tick, writes only land while stopped
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= `THD_RST_WORD;
        end else if (cmd[`THD_CMD_CNT_CLR]) begin
            cnt_q <= 16'h0000;
        end else if (cnt_wr && !run_q) begin
            cnt_q <= 16'(merge({16'h0000, cnt_q}, wdata_q, wstrb_q));
        end else if (wrap) begin
            cnt_q <= 16'h0000;
        end else if (tick) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // companion trigger selection and direction qualifier
    always_comb begin
        case (ctrl_q.trig_evt)
            3'h1: evt = i_t12.cmp_match[0];
            3'h2: evt = i_t12.cmp_match[1];
            3'h3: evt = i_t12.cmp_match[2];
            3'h4: evt = |i_t12.cmp_match;
            3'h5: evt = i_t12.period_match;
            3'h6: evt = i_t12.zero_match && !i_t12.count_down;
            3'h7: evt = i_t12.hall_change;
            default: evt = 1'b0;
        endcase
        case (ctrl_q.trig_dir)
            2'h1: trig = evt && !i_t12.count_down;
            2'h2: trig = evt && i_t12.count_down;
            2'h3: trig = evt;
            default: trig = 1'b0;
        endcase
    end

    // run flag: any start wins over a stop in the same cycle so no start is lost
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            run_q <= 1'b0;
        end else if (cmd[`THD_CMD_RUN_SET] || trig) begin
            run_q <= 1'b1;
        end else if (cmd[`THD_CMD_RUN_CLR]) begin
            run_q <= 1'b0;
        end else if (wrap && ctrl_q.single_shot) begin
            run_q <= 1'b0;
        end
    end

    // shadow transfer request and the active copies
    assign xfer = sreq_q && (wrap || !run_q);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sreq_q <= 1'b0;
        end else if (cmd[`THD_CMD_SREQ_SET]) begin
            sreq_q <= 1'b1;
        end else if (cmd[`THD_CMD_SREQ_CLR]) begin
            sreq_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            per_q <= `THD_RST_WORD;
            cmp_q <= `THD_RST_WORD;
        end else if (xfer) begin
            per_q <= per_shd_q;
            cmp_q <= cmp_shd_q;
        end
    end

    // timer status outputs, registered for glitch-free pins
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_period_match <= 1'b0;
            o_zero_match <= 1'b0;
            o_shadow_xfer <= 1'b0;
        end else begin
            o_period_match <= run_q && pm;
            o_zero_match <= (cnt_q == 16'h0000);
            o_shadow_xfer <= xfer;
        end
    end

    // comparator pins are asynchronous: two-flop sync, edge taken after that
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pos_m_q <= 3'h7;
            pos_q <= 3'h7;
            pos_d1_q <= 3'h7;
        end else begin
            pos_m_q <= i_chan_cmp;
            pos_q <= pos_m_q;
            pos_d1_q <= pos_q;
        end
    end

    assign hyst = {ctrl_q.mode2 == `THD_MODE_HYST, ctrl_q.mode1 == `THD_MODE_HYST,
                   ctrl_q.mode0 == `THD_MODE_HYST};
    assign fall = pos_d1_q & ~pos_q;

    // channel state bits; a set beats a software clear, but in hysteresis mode
    // a low comparator blocks the set entirely
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= 3'h0;
        end else begin
            for (int c = 0; c < `THD_NCH; c++) begin
                if (hyst[c] && (fall[c] || !pos_q[c])) begin
                    st_q[c] <= fall[c] ? 1'b0 : st_q[c];
                end else if (i_chan_set[c]) begin
                    st_q[c] <= 1'b1;
                end else if (cmd[`THD_CMD_ST_CLR + c]) begin
                    st_q[c] <= 1'b0;
                end
            end
        end
    end

    // outputs: passive (low) while the comparator is low in hysteresis mode
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_chan_out <= 3'h0;
        end else begin
            o_chan_out <= st_q & (~hyst | pos_q);
        end
    end

    // checks
    a_hyst_fall_clear: assert property (@(posedge i_clk) disable iff (i_rst)
        hyst[0] && fall[0] |=> !st_q[0]) else $error("state bit not cleared on falling edge");
    a_hyst_out_passive: assert property (@(posedge i_clk) disable iff (i_rst)
        hyst[0] && !pos_q[0] |=> !o_chan_out[0]) else $error("output active while input low");
    a_hyst_no_set: assert property (@(posedge i_clk) disable iff (i_rst)
        hyst[0] && !pos_q[0] && !st_q[0] |=> !st_q[0]) else $error("state bit set while low");
    a_count_inc: assert property (@(posedge i_clk) disable iff (i_rst)
        tick && !pm && !cmd[`THD_CMD_CNT_CLR] |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("counter did not step by one");
    // a start may tick at once at divisor one, so only the stopped cycle itself is tick-free
    a_psc_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        !run_q |-> !tick ##1 psc_q == '0)
        else $error("prescaler ran while stopped");
    a_period_wrap: assert property (@(posedge i_clk) disable iff (i_rst)
        wrap |=> cnt_q == 16'h0000 ##1 o_zero_match) else $error("no wrap after period match");
    a_count_locked: assert property (@(posedge i_clk) disable iff (i_rst)
        run_q && cnt_wr && !tick && !cmd[`THD_CMD_CNT_CLR] |=> $stable(cnt_q))
        else $error("count written while running");
    a_shadow_load: assert property (@(posedge i_clk) disable iff (i_rst)
        xfer |=> per_q == $past(per_shd_q) && cmp_q == $past(cmp_shd_q))
        else $error("shadow transfer did not load");
    a_run_start: assert property (@(posedge i_clk) disable iff (i_rst)
        cmd[`THD_CMD_RUN_SET] |=> run_q) else $error("run set ignored");
    a_single_stop: assert property (@(posedge i_clk) disable iff (i_rst)
        wrap && ctrl_q.single_shot && !trig && !cmd[`THD_CMD_RUN_SET] |=> !run_q)
        else $error("single shot did not stop");
    a_trig_start: assert property (@(posedge i_clk) disable iff (i_rst)
        trig |=> run_q) else $error("trigger did not start timer");

    c_wrap: cover property (@(posedge i_clk) disable iff (i_rst) wrap);
    c_hyst_cut: cover property (@(posedge i_clk) disable iff (i_rst) hyst[0] && fall[0] && st_q[0]);
    // reload taken at a wrap while the timer keeps running
    c_xfer_run: cover property (@(posedge i_clk) disable iff (i_rst) xfer && run_q);
    c_trig_single: cover property (@(posedge i_clk) disable iff (i_rst)
        trig ##[1:200] (wrap && ctrl_q.single_shot));

endmodule // thd_timer

// ---- verification/thd_partner.sv ----
// companion timer events, channel set pulses and comparator pins for the shutdown timer
`timescale 1ns/1ps

module thd_partner
    import thd_pkg::*;
(
    input wire logic i_clk,
    output thd_t12_ev_t o_t12,
    output logic [2:0] o_set,
    output logic [2:0] o_cmp
);
    // idle: no events, comparators report no fault
    initial begin
        o_t12 = '0;
        o_set = 3'h0;
        o_cmp = 3'h7;
    end

    // one-cycle event pulse; direction is a level and stays after the pulse
    task automatic fire(input logic [6:0] ev, input logic dn);
        @(posedge i_clk);
        o_t12 <= thd_t12_ev_t'(ev | {5'h00, dn, 1'b0});
        @(posedge i_clk);
        o_t12 <= thd_t12_ev_t'({5'h00, dn, 1'b0});
    endtask

    // one-cycle set request per channel
    task automatic set_state(input logic [2:0] ch);
        @(posedge i_clk);
        o_set <= ch;
        @(posedge i_clk);
        o_set <= 3'h0;
    endtask

    // comparator level; the design resynchronises it
    task automatic comp(input logic [2:0] v);
        @(posedge i_clk);
        o_cmp <= v;
    endtask
endmodule // thd_partner

// ---- verification/thd_timer_tb_top.sv ----
// register-level bench for the shutdown timer
`timescale 1ns/1ps
`include "thd_defines.svh"

module thd_timer_tb_top;
    import thd_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic [31:0] rdata;
    logic awready, wready, bvalid, arready, rvalid, pm, zm, sx;
    logic [1:0] bresp, rresp;
    logic [2:0] cset, ccmp, cout;
    thd_t12_ev_t t12;
    int mismatches = 0;
    int checks = 0;
    // trigger table: event code, direction code, companion down, event vector, expect start
    logic [13:0] ev_tab [13] = '{{3'h1, 2'h3, 1'b0, 7'h10, 1'b1}, {3'h2, 2'h3, 1'b0, 7'h20, 1'b1},
        {3'h3, 2'h3, 1'b0, 7'h40, 1'b1}, {3'h4, 2'h3, 1'b0, 7'h20, 1'b1},
        {3'h5, 2'h3, 1'b0, 7'h08, 1'b1}, {3'h6, 2'h3, 1'b0, 7'h04, 1'b1},
        {3'h7, 2'h3, 1'b0, 7'h01, 1'b1}, {3'h1, 2'h3, 1'b0, 7'h20, 1'b0},
        {3'h0, 2'h3, 1'b0, 7'h7d, 1'b0}, {3'h5, 2'h0, 1'b0, 7'h08, 1'b0},
        {3'h5, 2'h1, 1'b1, 7'h08, 1'b0}, {3'h5, 2'h2, 1'b1, 7'h08, 1'b1},
        {3'h5, 2'h2, 1'b0, 7'h08, 1'b0}};
    // divider settings and the clocks per tick they give
    logic [31:0] cfg [3] = '{32'h0, 32'h3, 32'h8};
    int dv [3] = '{1, 8, 256};

    always #25 i_clk = ~i_clk;

    thd_timer uut (.i_clk(i_clk), .i_rst(i_rst), .i_s_awaddr(awaddr), .i_s_awvalid(awvalid),
        .o_s_awready(awready), .i_s_wdata(wdata), .i_s_wstrb(wstrb), .i_s_wvalid(wvalid),
        .o_s_wready(wready), .o_s_bresp(bresp), .o_s_bvalid(bvalid), .i_s_bready(bready),
        .i_s_araddr(araddr), .i_s_arvalid(arvalid), .o_s_arready(arready), .o_s_rdata(rdata),
        .o_s_rresp(rresp), .o_s_rvalid(rvalid), .i_s_rready(rready), .i_t12(t12),
        .i_chan_set(cset), .i_chan_cmp(ccmp), .o_chan_out(cout), .o_period_match(pm),
        .o_zero_match(zm), .o_shadow_xfer(sx));

    thd_partner pm_i (.i_clk(i_clk), .o_t12(t12), .o_set(cset), .o_cmp(ccmp));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    // each channel drops its valid once taken; bready held until bvalid is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        int n = 0;
        logic ah = 1'b0;
        logic wh = 1'b0;
        @(posedge i_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
            if (!ah && awready) begin
                ah = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wh && wready) begin
                wh = 1'b1;
                wvalid <= 1'b0;
            end
        end while (bvalid !== 1'b1 && n < 100);
        bready <= 1'b0;
        chk({31'h0, bvalid}, 32'h1, "write answer");
        chk({30'h0, bresp}, {30'h0, er}, "write response");
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                      input logic [1:0] er);
        int n = 0;
        @(posedge i_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        rready <= 1'b0;
        chk({31'h0, rvalid}, 32'h1, "read answer");
        chk(rdata & m, exp, "read data");
        chk({30'h0, rresp}, {30'h0, er}, "read response");
    endtask

    // clocks from one period-match rise to the next; bounded so a dead timer cannot hang
    task automatic per(input int exp);
        int c = 0;
        while (pm !== 1'b1 && c < 40000) begin
            @(posedge i_clk);
            c++;
        end
        c = 0;
        do begin
            @(posedge i_clk);
            c++;
        end while (pm === 1'b1 && c < 40000);
        while (pm !== 1'b1 && c < 40000) begin
            @(posedge i_clk);
            c++;
        end
        chk(c, exp, "period length");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // watchdog sized well above the longest period measurement
    initial begin
        repeat (60000) @(posedge i_clk);
        mismatches++;
        $display("wrong value at %0t: watchdog expired", $time);
        close_out();
    end

    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        // reset contents and refused accesses
        rd(`THD_OFF_COUNT, 32'h0, 32'hffffffff, `THD_RESP_OK);
        rd(`THD_OFF_CTRL, `THD_RST_CTRL, 32'hffffffff, `THD_RESP_OK);
        rd(8'h1c, 32'h0, 32'hffffffff, `THD_RESP_ERR);
        wr(`THD_OFF_CMP_ACT, 32'h5, `THD_RESP_ERR);
        // shadow loads only through a request; period reads give the active value
        wr(`THD_OFF_PERIOD, 32'h5, `THD_RESP_OK);
        wr(`THD_OFF_CMP_SHD, 32'h3, `THD_RESP_OK);
        rd(`THD_OFF_PERIOD, 32'h0, 32'hffffffff, `THD_RESP_OK);
        wr(`THD_OFF_CMD, 32'h8, `THD_RESP_OK);
        rd(`THD_OFF_STATUS, 32'h2, 32'h2, `THD_RESP_OK);
        chk({31'h0, sx}, 32'h1, "shadow transfer while stopped");
        rd(`THD_OFF_PERIOD, 32'h5, 32'hffffffff, `THD_RESP_OK);
        rd(`THD_OFF_CMP_ACT, 32'h3, 32'hffffffff, `THD_RESP_OK);
        wr(`THD_OFF_CMD, 32'h10, `THD_RESP_OK);
        rd(`THD_OFF_STATUS, 32'h0, 32'h2, `THD_RESP_OK);
        chk({31'h0, sx}, 32'h0, "shadow transfer after clear");
        wr(`THD_OFF_PERIOD, 32'h9, `THD_RESP_OK);
        rd(`THD_OFF_PERIOD, 32'h5, 32'hffffffff, `THD_RESP_OK);
        // stopped count takes writes; clear zeroes it
        wr(`THD_OFF_COUNT, 32'h7, `THD_RESP_OK);
        rd(`THD_OFF_COUNT, 32'h7, 32'hffffffff, `THD_RESP_OK);
        wr(`THD_OFF_CMD, 32'h4, `THD_RESP_OK);
        rd(`THD_OFF_COUNT, 32'h0, 32'hffffffff, `THD_RESP_OK);
        // period length for several dividers, restarting each time
        foreach (cfg[i]) begin
            wr(`THD_OFF_CTRL, cfg[i], `THD_RESP_OK);
            wr(`THD_OFF_CMD, 32'h1, `THD_RESP_OK);
            per(6 * dv[i]);
            wr(`THD_OFF_CMD, 32'h2, `THD_RESP_OK);
        end
        rd(`THD_OFF_STATUS, 32'h0, 32'h1, `THD_RESP_OK);
        // a command without byte lane 0 must not start the timer
        wstrb <= 4'he;
        wr(`THD_OFF_CMD, 32'h1, `THD_RESP_OK);
        wstrb <= 4'hf;
        rd(`THD_OFF_STATUS, 32'h0, 32'h1, `THD_RESP_OK);
        // slowest plain divider keeps the count at zero during these accesses
        wr(`THD_OFF_CMD, 32'h4, `THD_RESP_OK);
        wr(`THD_OFF_CTRL, 32'h7, `THD_RESP_OK);
        wr(`THD_OFF_CMD, 32'h1, `THD_RESP_OK);
        wr(`THD_OFF_COUNT, 32'h1234, `THD_RESP_OK);
        rd(`THD_OFF_COUNT, 32'h0, 32'hffffffff, `THD_RESP_OK);
        wr(`THD_OFF_CMD, 32'h4, `THD_RESP_OK);
        rd(`THD_OFF_STATUS, 32'h1, 32'h1, `THD_RESP_OK);
        // new period taken at a wrap while running
        wr(`THD_OFF_CTRL, 32'h0, `THD_RESP_OK);
        wr(`THD_OFF_PERIOD, 32'h2, `THD_RESP_OK);
        wr(`THD_OFF_CMD, 32'h8, `THD_RESP_OK);
        repeat (8) @(posedge i_clk);
        per(3);
        rd(`THD_OFF_PERIOD, 32'h2, 32'hffffffff, `THD_RESP_OK);
        wr(`THD_OFF_CMD, 32'h12, `THD_RESP_OK);
        // single shot: three full-rate ticks then stop at zero; wait covers them with margin
        wr(`THD_OFF_CTRL, 32'h10, `THD_RESP_OK);
        wr(`THD_OFF_CMD, 32'h5, `THD_RESP_OK);
        repeat (12) @(posedge i_clk);
        rd(`THD_OFF_STATUS, 32'h4, 32'h5, `THD_RESP_OK);
        rd(`THD_OFF_COUNT, 32'h0, 32'hffffffff, `THD_RESP_OK);
        chk({31'h0, zm}, 32'h1, "zero match");
        // hardware start for every event and direction code
        foreach (ev_tab[i]) begin
            wr(`THD_OFF_CTRL, {22'h0, ev_tab[i][10:9], ev_tab[i][13:11], 5'h07}, `THD_RESP_OK);
            pm_i.fire(ev_tab[i][7:1], ev_tab[i][8]);
            rd(`THD_OFF_STATUS, {31'h0, ev_tab[i][0]}, 32'h1, `THD_RESP_OK);
            wr(`THD_OFF_CMD, 32'h2, `THD_RESP_OK);
        end
        // channel 0 in shutdown mode, channel 1 plain
        wr(`THD_OFF_CTRL, 32'h0009_0000, `THD_RESP_OK);
        pm_i.set_state(3'h3);
        repeat (2) @(posedge i_clk);
        chk({29'h0, cout}, 32'h3, "outputs before fault");
        pm_i.comp(3'h4);
        repeat (4) @(posedge i_clk);
        chk({29'h0, cout}, 32'h2, "outputs during fault");
        rd(`THD_OFF_STATUS, 32'h20, 32'h70, `THD_RESP_OK);
        pm_i.set_state(3'h1);
        rd(`THD_OFF_STATUS, 32'h20, 32'h70, `THD_RESP_OK);
        pm_i.comp(3'h7);
        repeat (4) @(posedge i_clk);
        chk({29'h0, cout}, 32'h2, "outputs after fault");
        pm_i.set_state(3'h1);
        repeat (2) @(posedge i_clk);
        chk({29'h0, cout}, 32'h3, "outputs after set");
        close_out();
    end
endmodule // thd_timer_tb_top
